// [rtl/cksw_params.svh]
// Function
// - debug reads live line state, upper zero
// - scratch byte read/write/set/clear, resets zero
// - control register write/set/clear at three addresses
// - irq enable write/set/clear at three addresses
// - data line one high without rx route
// - bit one grounds id; bit zero reads zero
// - bit two routes data zero to dm
// - bit three routes dp to data one
// - bit four closes dm-left switch; bit7 zero
// - dp to right/mic if bit5 or bit6
// - uart data reaches enabled audio pins
// - audio switches disable single-ended receivers
// - id float rise raises alt interrupt
// - id float fall raises alt interrupt
// - irq enable bits 7:6,4:2 read zero
// - conversion done irq, ORed vendor enable
// - conversion done flag after conversion time
`ifndef CKSW_PARAMS_SVH
`define CKSW_PARAMS_SVH
`define CKSW_ADDR_DEBUG 6'h15
`define CKSW_ADDR_SCR_W 6'h16
`define CKSW_ADDR_SCR_S 6'h17
`define CKSW_ADDR_SCR_C 6'h18
`define CKSW_ADDR_CTL_W 6'h19
`define CKSW_ADDR_CTL_S 6'h1A
`define CKSW_ADDR_CTL_C 6'h1B
`define CKSW_ADDR_IEN_W 6'h1D
`define CKSW_ADDR_IEN_S 6'h1E
`define CKSW_ADDR_IEN_C 6'h1F
`define CKSW_CTL_MASK 8'h7E
`define CKSW_IEN_MASK 8'h23
`define CKSW_RESET_VAL 8'h00
`define CKSW_CONV_TIME_NS 282000
`define CKSW_CLK_PERIOD_NS 10
`endif

// [rtl/cksw_pkg.sv]
package cksw_pkg;
  typedef enum logic [1:0] {
    CKSW_OP_WRITE = 2'b00,
    CKSW_OP_SET = 2'b01,
    CKSW_OP_CLEAR = 2'b10,
    CKSW_OP_NONE = 2'b11
  } cksw_op_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic [5:0] addr;
    logic [7:0] data;
  } cksw_req_t;
  typedef struct packed {
    logic valid;
    logic hit;
    logic [7:0] data;
  } cksw_rsp_t;
  typedef struct packed {
    logic idGround;
    logic dmFromTx;
    logic data1FromDp;
    logic data1High;
    logic dmToLeft;
    logic dpToRightMic;
    logic seRxDisable;
  } cksw_route_t;
endpackage

// [rtl/cksw_regs.sv]
`timescale 1ns/1ps
`include "cksw_params.svh"
module cksw_regs #(
  parameter int unsigned CONV_CYCLES =
    `CKSW_CONV_TIME_NS / `CKSW_CLK_PERIOD_NS
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clkEn,
  // register access from the link
  input wire cksw_pkg::cksw_req_t regReq,
  output cksw_pkg::cksw_rsp_t regRsp,
  // device status
  input wire logic [1:0] lineState,
  input wire logic idFloating,
  input wire logic convStart,
  input wire logic vendorRidIrqEn,
  input wire logic convDoneClear,
  // switch routing and interrupt
  output cksw_pkg::cksw_route_t route,
  output logic idResistorConvDone,
  output logic altInt
);
  import cksw_pkg::*;

  // counter is 24 bits wide; longer conversions are refused
  if (CONV_CYCLES < 1) begin : g_convShort
    $error("conversion cycle count must be at least one");
  end
  if (CONV_CYCLES > 32'h00FFFFFF) begin : g_convLong
    $error("conversion cycle count exceeds the counter");
  end

  logic [7:0] scratchReg;
  logic [7:0] ctlReg;
  logic [7:0] ienReg;
  logic idFloatPrevReg;
  logic [23:0] convCntReg;
  logic convBusyReg;
  logic convDonePrevReg;
  cksw_op_t scrOp, ctlOp, ienOp;
  logic [7:0] rdData;
  logic rdHit;
  // helpers for the edge detectors, interrupt enable and named register bit views
  logic primedReg;
  logic id_open_rise_en;
  logic id_open_fall_en;
  logic convDoneRise;
  logic ridIrqEnable;
  logic idGroundDrive;
  logic uartTxRouteEn;
  logic uartRxRouteEn;
  logic leftAudioSwitch;
  logic rightAudioSwitch;
  logic monoMicSwitch;
  logic idOpenRiseEn;
  logic idOpenFallEn;
  logic idResistorIrqEn;

  // named views of the register bits
  assign idGroundDrive = ctlReg[1];
  assign uartTxRouteEn = ctlReg[2];
  assign uartRxRouteEn = ctlReg[3];
  assign leftAudioSwitch = ctlReg[4];
  assign rightAudioSwitch = ctlReg[5];
  assign monoMicSwitch = ctlReg[6];
  assign idOpenRiseEn = ienReg[0];
  assign idOpenFallEn = ienReg[1];
  assign idResistorIrqEn = ienReg[5];

  function automatic logic [7:0] applyOp(input cksw_op_t op,
      input logic [7:0] cur, input logic [7:0] wd,
      input logic [7:0] mask);
    logic [7:0] r;
    r = cur;
    case (op)
      CKSW_OP_WRITE: r = wd;
      CKSW_OP_SET: r = cur | wd;
      CKSW_OP_CLEAR: r = cur & ~wd;
      default: r = cur;
    endcase
    return r & mask;
  endfunction

  // one decoder per register keeps each write path separate
  always_comb begin
    scrOp = CKSW_OP_NONE;
    if (regReq.valid && regReq.write) begin
      case (regReq.addr)
        `CKSW_ADDR_SCR_W: scrOp = CKSW_OP_WRITE;
        `CKSW_ADDR_SCR_S: scrOp = CKSW_OP_SET;
        `CKSW_ADDR_SCR_C: scrOp = CKSW_OP_CLEAR;
        default: ;
      endcase
    end
  end

  always_comb begin
    ctlOp = CKSW_OP_NONE;
    if (regReq.valid && regReq.write) begin
      case (regReq.addr)
        `CKSW_ADDR_CTL_W: ctlOp = CKSW_OP_WRITE;
        `CKSW_ADDR_CTL_S: ctlOp = CKSW_OP_SET;
        `CKSW_ADDR_CTL_C: ctlOp = CKSW_OP_CLEAR;
        default: ;
      endcase
    end
  end

  always_comb begin
    ienOp = CKSW_OP_NONE;
    if (regReq.valid && regReq.write) begin
      case (regReq.addr)
        `CKSW_ADDR_IEN_W: ienOp = CKSW_OP_WRITE;
        `CKSW_ADDR_IEN_S: ienOp = CKSW_OP_SET;
        `CKSW_ADDR_IEN_C: ienOp = CKSW_OP_CLEAR;
        default: ;
      endcase
    end
  end

  // scratch steers nothing else
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      scratchReg <= `CKSW_RESET_VAL;
    end else if (clkEn) begin
      scratchReg <= applyOp(scrOp, scratchReg, regReq.data,
        8'hFF);
    end
  end

  // bit zero and bit seven are wired to zero by the mask
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctlReg <= `CKSW_RESET_VAL;
    end else if (clkEn) begin
      ctlReg <= applyOp(ctlOp, ctlReg, regReq.data,
        `CKSW_CTL_MASK);
    end
  end

  // unimplemented detect enables read back as zero
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ienReg <= `CKSW_RESET_VAL;
    end else if (clkEn) begin
      ienReg <= applyOp(ienOp, ienReg, regReq.data,
        `CKSW_IEN_MASK);
    end
  end

  // reads have no side effects, so each alias returns the same byte
  always_comb begin
    rdHit = 1'b1;
    case (regReq.addr)
      `CKSW_ADDR_DEBUG: rdData = {6'h00, lineState};
      `CKSW_ADDR_SCR_W: rdData = scratchReg;
      `CKSW_ADDR_SCR_S: rdData = scratchReg;
      `CKSW_ADDR_SCR_C: rdData = scratchReg;
      `CKSW_ADDR_CTL_W: rdData = ctlReg;
      `CKSW_ADDR_CTL_S: rdData = ctlReg;
      `CKSW_ADDR_CTL_C: rdData = ctlReg;
      `CKSW_ADDR_IEN_W: rdData = ienReg;
      `CKSW_ADDR_IEN_S: rdData = ienReg;
      `CKSW_ADDR_IEN_C: rdData = ienReg;
      default: begin
        rdData = 8'h00;
        rdHit = 1'b0;
      end
    endcase
  end

  // answer stands one cycle, held while the enable is low
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      regRsp <= '0;
    end else if (clkEn) begin
      regRsp.valid <= regReq.valid && !regReq.write;
      regRsp.hit <= rdHit;
      regRsp.data <= rdData;
    end
  end

  // routing follows the register one cycle late, from flops
  logic idGroundReg;
  logic dmFromTxReg;
  logic data1FromDpReg;
  logic data1HighReg;
  logic dmToLeftReg;
  logic dpToRightMicReg;
  logic seRxDisableReg;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      idGroundReg <= 1'b0;
    end else if (clkEn) begin
      idGroundReg <= idGroundDrive;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dmFromTxReg <= 1'b0;
    end else if (clkEn) begin
      dmFromTxReg <= uartTxRouteEn;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      data1FromDpReg <= 1'b0;
    end else if (clkEn) begin
      data1FromDpReg <= uartRxRouteEn;
    end
  end

  // data line one idles high while the receive route is off
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      data1HighReg <= 1'b1;
    end else if (clkEn) begin
      data1HighReg <= !uartRxRouteEn;
    end
  end

  // switches pass whatever dm/dp carry, uart included
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dmToLeftReg <= 1'b0;
    end else if (clkEn) begin
      dmToLeftReg <= leftAudioSwitch;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dpToRightMicReg <= 1'b0;
    end else if (clkEn) begin
      dpToRightMicReg <= rightAudioSwitch | monoMicSwitch;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      seRxDisableReg <= 1'b0;
    end else if (clkEn) begin
      seRxDisableReg <= leftAudioSwitch | rightAudioSwitch
        | monoMicSwitch;
    end
  end

  assign route = {idGroundReg, dmFromTxReg, data1FromDpReg, data1HighReg,
    dmToLeftReg, dpToRightMicReg, seRxDisableReg};

  // conversion timer; a new start restarts the count
  logic convLastCycle;
  assign convLastCycle = convBusyReg
    && (convCntReg == 24'(CONV_CYCLES - 1));

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      convCntReg <= 24'h000000;
    end else if (clkEn) begin
      if (convStart) begin
        convCntReg <= 24'h000000;
      end else if (convBusyReg && !convLastCycle) begin
        convCntReg <= convCntReg + 24'h000001;
      end
    end
  end

  // busy spans exactly the programmed cycle count
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      convBusyReg <= 1'b0;
    end else if (clkEn) begin
      if (convStart) begin
        convBusyReg <= 1'b1;
      end else if (convLastCycle) begin
        convBusyReg <= 1'b0;
      end
    end
  end

  // finishing wins over a clear; a clear is ignored while busy
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      idResistorConvDone <= 1'b0;
    end else if (clkEn) begin
      if (convStart) begin
        idResistorConvDone <= 1'b0;
      end else if (convLastCycle) begin
        idResistorConvDone <= 1'b1;
      end else if (convDoneClear && !convBusyReg) begin
        idResistorConvDone <= 1'b0;
      end
    end
  end

  // the id float edge detectors stay blind on the first edge after reset,
  // so a pin already floating at release raises no interrupt
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      primedReg <= 1'b0;
    end else if (clkEn) begin
      primedReg <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      idFloatPrevReg <= 1'b0;
    end else if (clkEn) begin
      idFloatPrevReg <= idFloating;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      convDonePrevReg <= 1'b0;
    end else if (clkEn) begin
      convDonePrevReg <= idResistorConvDone;
    end
  end

  // vendor enable lives outside this block and is ORed in here
  assign id_open_rise_en = primedReg && idFloating && !idFloatPrevReg;
  assign id_open_fall_en = primedReg && !idFloating && idFloatPrevReg;
  assign convDoneRise = idResistorConvDone && !convDonePrevReg;
  assign ridIrqEnable = idResistorIrqEn || vendorRidIrqEn;

  // one pulse per cycle with any enabled event, all merged onto the alt interrupt
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      altInt <= 1'b0;
    end else if (clkEn) begin
      altInt <= (idOpenRiseEn && id_open_rise_en)
        || (idOpenFallEn && id_open_fall_en)
        || (ridIrqEnable && convDoneRise);
    end
  end
endmodule

// [sim/cksw_link_model.sv]
`timescale 1ns/1ps
module cksw_link_model (
  // link side of the register port
  input wire logic ref_clk,
  output cksw_pkg::cksw_req_t regReq,
  input wire cksw_pkg::cksw_rsp_t regRsp
);
  import cksw_pkg::*;
  cksw_rsp_t rsp;
  initial regReq = '0;
  task acc(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regReq <= '{1'b1, w, a, d};
    @(posedge ref_clk);
    // idle lines flip so a stale copy is never trusted
    regReq <= '{1'b0, ~w, ~a, ~d};
    #1 rsp = regRsp;
  endtask
endmodule

// [sim/cksw_regs_assertions.sv]
`timescale 1ns/1ps
module cksw_regs_assertions (
  // clock, reset
  input wire logic ref_clk,
  input wire logic resetn,
  // watched ports
  input wire cksw_pkg::cksw_req_t regReq,
  input wire cksw_pkg::cksw_rsp_t regRsp,
  input wire logic [1:0] lineState,
  input wire cksw_pkg::cksw_route_t route
);
  import cksw_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  wire r = regReq.valid && !regReq.write;
  wire w = regReq.valid && regReq.write && regReq.addr == 6'h19;
  wire [7:0] d = regReq.data;
  wire cw = regReq.valid && regReq.write
    && regReq.addr inside {6'h19, 6'h1A, 6'h1B};
  property p_dbg; r && regReq.addr == 6'h15 |=> regRsp.data[7:2] == 6'h00
    && regRsp.data[1:0] == $past(lineState); endproperty
  property p_ien; r && regReq.addr inside {6'h1D, 6'h1E, 6'h1F} |=>
    (regRsp.data & 8'hDC) == 8'h00; endproperty
  property p_hi; route.data1High != route.data1FromDp; endproperty
  property p_se; route.seRxDisable == (route.dmToLeft | route.dpToRightMic);
    endproperty
  property p_id; w ##1 !cw |=> route.idGround == $past(d[1], 2);
    endproperty
  property p_tx; w ##1 !cw |=> route.dmFromTx == $past(d[2], 2);
    endproperty
  property p_rx; w ##1 !cw |=> route.data1FromDp == $past(d[3], 2);
    endproperty
  property p_lt; w ##1 !cw |=> route.dmToLeft == $past(d[4], 2);
    endproperty
  a_dbg: assert property (p_dbg) else $error("bad debug");
  a_ien: assert property (p_ien) else $error("bad enable");
  a_hi: assert property (p_hi) else $error("bad data1");
  a_se: assert property (p_se) else $error("bad receiver");
  a_id: assert property (p_id) else $error("bad id");
  a_tx: assert property (p_tx) else $error("bad tx");
  a_rx: assert property (p_rx) else $error("bad rx");
  a_lt: assert property (p_lt) else $error("bad left");
  c_dbg: cover property (r && regReq.addr == 6'h15);
  c_se: cover property (route.seRxDisable);
  c_miss: cover property (regRsp.valid && !regRsp.hit);
endmodule
bind cksw_regs cksw_regs_assertions u_chk (.ref_clk, .resetn, .regReq,
  .regRsp, .lineState, .route);

// [sim/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import cksw_pkg::*;
  logic ref_clk = 0, resetn = 0, idFloating = 0;
  logic convStart = 0, convDoneClear = 0, done, altInt;
  logic vendorIrq = 0;
  logic [1:0] lineState = 2'h2;
  cksw_req_t regReq;
  cksw_rsp_t regRsp;
  cksw_route_t route;
  int fail_count = 0, total_checks = 0, pulses = 0, p;
  // {write, 0, addr, data or expected read}
  logic [15:0] ops[20] = '{16'h1600, 16'h1900, 16'h1D00, 16'h95FF,
    16'h1502, 16'h96A5, 16'h970A, 16'h9805, 16'h16AA, 16'h17AA, 16'h18AA,
    16'h99FF, 16'h197E, 16'h9B78, 16'h1A06, 16'h9A08, 16'h1B0E, 16'h9DFF,
    16'h1E23, 16'h1C00};
  logic [15:0] rt[6] = '{16'h0E70, 16'h0668, 16'h200B, 16'h400B,
    16'h100D, 16'h0008};
  initial forever #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (altInt === 1'b1) pulses++;
  cksw_regs #(.CONV_CYCLES(20)) u_dut (.ref_clk, .resetn, .clkEn(1'b1),
    .regReq, .regRsp, .lineState, .idFloating, .convStart,
    .vendorRidIrqEn(vendorIrq), .convDoneClear, .route,
    .idResistorConvDone(done), .altInt);
  cksw_link_model u_link (.ref_clk, .regReq, .regRsp);
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task pulse(input logic v, input logic [7:0] e);
    p = pulses;
    @(posedge ref_clk);
    idFloating <= v;
    repeat (4) @(posedge ref_clk);
    #1 chk("alt irq", e, 8'(pulses - p));
  endtask
  task conv(input logic [7:0] e);
    p = pulses;
    @(posedge ref_clk);
    convStart <= 1'b1;
    @(posedge ref_clk);
    convStart <= 1'b0;
    repeat (19) @(posedge ref_clk);
    #1 chk("busy", 8'h00, {7'h0, done});
    @(posedge ref_clk);
    #1 chk("done", 8'h01, {7'h0, done});
    repeat (3) @(posedge ref_clk);
    #1 chk("conv irq", e, 8'(pulses - p));
    @(posedge ref_clk);
    convDoneClear <= 1'b1;
    @(posedge ref_clk);
    convDoneClear <= 1'b0;
    @(posedge ref_clk);
    #1 chk("clear", 8'h00, {7'h0, done});
  endtask
  task final_report;
    if (fail_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge ref_clk);
    fail_count++;
    final_report;
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    chk("route", 8'h08, {1'b0, route});
    foreach (ops[i]) begin
      u_link.acc(ops[i][15], ops[i][13:8], ops[i][7:0]);
      if (!ops[i][15]) chk("reg", ops[i][7:0], u_link.rsp.data);
      chk("valid", {7'h0, !ops[i][15]}, {7'h0, u_link.rsp.valid});
    end
    chk("hit", 8'h00, {7'h0, u_link.rsp.hit});
    foreach (rt[i]) begin
      u_link.acc(1'b1, 6'h19, rt[i][15:8]);
      u_link.acc(1'b0, 6'h19, 8'h00);
      chk("ctl", rt[i][15:8], u_link.rsp.data);
      chk("route", rt[i][7:0], {1'b0, route});
    end
    pulse(1'b1, 8'h01);
    u_link.acc(1'b1, 6'h1F, 8'h01);
    pulse(1'b0, 8'h01);
    u_link.acc(1'b1, 6'h1F, 8'h02);
    pulse(1'b1, 8'h00);
    conv(8'h01);
    u_link.acc(1'b1, 6'h1F, 8'h20);
    @(posedge ref_clk);
    vendorIrq <= 1'b1;
    conv(8'h01);
    @(posedge ref_clk);
    vendorIrq <= 1'b0;
    conv(8'h00);
    @(posedge ref_clk);
    lineState <= 2'h1;
    u_link.acc(1'b0, 6'h15, 8'h00);
    chk("debug", 8'h01, u_link.rsp.data);
    final_report;
  end
endmodule
